// ### rtl/cbg_pkg.sv
// shared constants for the processor card clock and bus glue
package cbg_pkg;
   localparam int          DATA_W       = 16;       // data and address width
   localparam int          COND_N       = 16;       // branch condition inputs
   localparam int          SEL_W        = 4;        // condition select width
   localparam int          RING_W       = 4;        // slot ring length
   localparam logic [3:0]  RING_RESET   = 4'h7;     // 0111 loaded under clear
   localparam int          SLOT1_BIT    = 3;        // ring tap for slot one
   localparam int          SLOT2_BIT    = 2;        // ring tap for slot two
   localparam int          SLOT3_BIT    = 1;        // ring tap for slot three
   localparam int          SLOT4_BIT    = 0;        // ring tap for slot four
   localparam logic [15:0] TOP_ADDRESS  = 16'hFFFF; // octal 177777
   localparam logic [15:0] ADDR_RESET   = 16'h0000; // address register at reset
   localparam logic [15:0] DATA_RESET   = 16'h0000; // data latches at reset
endpackage

// ### rtl/cbg_ring.sv
// four-stage recirculating slot ring of the clock generator
`timescale 1ns/10ps
module cbg_ring
#(
   parameter int         W     = 4,       // ring length
   parameter logic [3:0] PRELD = 4'h7     // pattern held under clear
)
(
   input  wire logic         clk_in,      // master clock
   input  wire logic         nrst_in,     // async clear, active low
   output logic [W-1:0]      ring_out     // ring stages
);
   // only a four-stage ring gives the two-phase slot walk
   if (W != 4)
   begin : g_bad_len
      $error("cbg_ring supports a length of four only");
   end

   // clear forces the preload, then the last stage feeds the first
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         ring_out <= PRELD;                          // [RULE1]
      else
         ring_out <= {ring_out[0], ring_out[W-1:1]}; // [RULE2]
   end
endmodule

// ### rtl/cbg_top.sv
// processor card glue: two-phase clocks, sync, branch mux, bus control
// What the document requires
// RULE1: under master clear the slot ring loads 0111.
// RULE2: after clear the ring rotates each clock, last stage into first.
// RULE3: phase one is slot one OR slot three strobes.
// RULE4: phase two is slot two OR slot four strobes.
// RULE5: phase one and phase two are never high together.
// RULE6: an active-low slot four strobe is offered to users.
// RULE7: reset controller holds master clear low after supplies settle. No reset controller here; NRST_IN comes in from outside.
// RULE8: rising sync is aligned to the falling edge of slot three.
// RULE9: sixteen active-low branch conditions go through a 16-to-1 mux.
// RULE10: external branch is taken when the selected input is 0.
// RULE11: sixteen data lines are buffered both ways onto the backplane.
// RULE12: direction latch idles in slot one, sets on its end if drive.
// RULE13: address register captures in slot four on address operations.
// RULE14: address drivers float on float input only while bus granted.
// RULE15: force-top input makes the stored address 177777 on a trap.
// RULE16: oscillator output is offered at the connector.
// RULE17: a DMA master requests and waits for grant before using the bus. No bus request logic here; the grant only gates the address float.
// RULE18: a DMA master drives control lines except the inactive strobe. This block has no DMA master logic.
`timescale 1ns/10ps
module cbg_top
   import cbg_pkg::*;
#(
   parameter int DW = cbg_pkg::DATA_W      // data and address width
)
(
   input  wire logic                 CLK_SYS_IN,          // master clock
   input  wire logic                 NRST_IN,             // master clear
   input  wire logic                 CPU_SYNC_N_IN,       // cpu sync request
   input  wire logic [15:0]          EXT_BRANCH_COND_N_IN,// branch conds
   input  wire logic [3:0]           COND_SEL_IN,         // condition select
   input  wire logic                 CPU_DRIVE_DIR_IN,    // cpu drives bus
   input  wire logic [DW-1:0]        CPU_DATA_IN,         // data from cpu
   input  wire logic [DW-1:0]        BUS_DATA_IN,         // backplane data
   input  wire logic                 ADDR_READ_OP_N_IN,   // address read op
   input  wire logic                 BUS_ADDR_LOAD_N_IN,  // address load op
   input  wire logic                 INTR_ACK_OP_N_IN,    // interrupt ack op
   input  wire logic                 FLOAT_ADDR_REG_N_IN, // float address
   input  wire logic                 BUS_GRANT_N_IN,      // cpu bus grant
   input  wire logic                 FORCE_TOP_ADDRESS_N_IN, // force top
   input  wire logic                 OSC_IN,              // crystal level
   output logic                      PHASE1_OUT,          // cpu phase one
   output logic                      PHASE2_OUT,          // cpu phase two
   output logic                      SLOT_STROBE_1_N_OUT, // slot one strobe
   output logic                      SLOT_STROBE_3_N_OUT, // slot three
   output logic                      SLOT_STROBE_4_N_OUT, // user slot four
   output logic                      CPU_SYNC_N_OUT,      // aligned sync
   output logic                      EXT_BRANCH_TAKE_OUT, // branch taken
   output logic [DW-1:0]             BUS_DATA_OUT,        // to backplane
   output logic                      BUS_DATA_OE_OUT,     // backplane drive
   output logic [DW-1:0]             CPU_DATA_OUT,        // to cpu
   output logic [DW-1:0]             ADDR_OUT,            // address bus
   output logic                      ADDR_OE_OUT,         // address drive
   output logic                      CRYSTAL_OSC_OUT      // oscillator pin
);
   import cbg_pkg::*;

   logic [RING_W-1:0] ring;
   logic              s1, s2, s3, s4;
   logic              s3_prev;
   logic              s1_prev;
   logic              next_phase1;
   logic              next_phase2;
   logic              addr_op;

   // the buffers and the address register are laid out for sixteen bits
   if (DW != DATA_W)
   begin : g_bad_width
      $error("cbg_top supports a sixteen bit bus only");
   end

   cbg_ring #(
      .W     (RING_W),
      .PRELD (RING_RESET)
   ) cbg_ring_i (
      .clk_in   (CLK_SYS_IN),
      .nrst_in  (NRST_IN),
      .ring_out (ring)
   );

   // slot strobes are active when the ring tap is low
   assign s1 = ~ring[SLOT1_BIT];
   assign s2 = ~ring[SLOT2_BIT];
   assign s3 = ~ring[SLOT3_BIT];
   assign s4 = ~ring[SLOT4_BIT];

   // phases from strobe pairs; the cross term keeps them disjoint even if
   // the ring were ever corrupted into two low taps
   assign next_phase1 = (s1 | s3);                // [RULE3]
   assign next_phase2 = (s2 | s4) & ~next_phase1; // [RULE4] [RULE5]

   // phase outputs are registered, one master clock behind the taps
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         PHASE1_OUT <= 1'b0;
         PHASE2_OUT <= 1'b0;
      end
      else
      begin
         PHASE1_OUT <= next_phase1;               // [RULE3]
         PHASE2_OUT <= next_phase2 & ~next_phase1; // [RULE5]
      end
   end

   // strobes to the card pins, registered like the phases
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         SLOT_STROBE_1_N_OUT <= 1'b1;
         SLOT_STROBE_3_N_OUT <= 1'b1;
         SLOT_STROBE_4_N_OUT <= 1'b1;
      end
      else
      begin
         SLOT_STROBE_1_N_OUT <= ~s1;
         SLOT_STROBE_3_N_OUT <= ~s3;
         SLOT_STROBE_4_N_OUT <= ~s4;               // [RULE6]
      end
   end

   // edge history of the slot strobes
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         s3_prev <= 1'b0;
         s1_prev <= 1'b0;
      end
      else
      begin
         s3_prev <= s3;
         s1_prev <= s1;
      end
   end

   // sync may only rise as slot three begins (strobe falling edge), so a
   // released sync never lands mid-cycle; falling passes at once
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         CPU_SYNC_N_OUT <= 1'b0;
      else if (!CPU_SYNC_N_IN)
         CPU_SYNC_N_OUT <= 1'b0;
      else if (s3 && !s3_prev)
         CPU_SYNC_N_OUT <= 1'b1;                   // [RULE8]
   end

   // selected condition is active low: a 0 takes the branch
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         EXT_BRANCH_TAKE_OUT <= 1'b0;
      else
         EXT_BRANCH_TAKE_OUT <=
            ~EXT_BRANCH_COND_N_IN[COND_SEL_IN];    // [RULE9] [RULE10]
   end

   // direction latch: idle through slot one, decided as it ends
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         BUS_DATA_OE_OUT <= 1'b0;
      else if (s1)
         BUS_DATA_OE_OUT <= BUS_DATA_OE_OUT;       // [RULE12]
      else if (s1_prev)
         BUS_DATA_OE_OUT <= CPU_DRIVE_DIR_IN;      // [RULE12]
   end

   // data buffered both ways; registered to keep outputs on flops
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         BUS_DATA_OUT <= DATA_RESET;
         CPU_DATA_OUT <= DATA_RESET;
      end
      else
      begin
         BUS_DATA_OUT <= CPU_DATA_IN;              // [RULE11]
         CPU_DATA_OUT <= BUS_DATA_IN;              // [RULE11]
      end
   end

   // address capture in slot four on any address-carrying operation
   assign addr_op = ~ADDR_READ_OP_N_IN | ~BUS_ADDR_LOAD_N_IN |
                    ~INTR_ACK_OP_N_IN;

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         ADDR_OUT <= ADDR_RESET;
      else if (s4 && addr_op)
      begin
         if (!FORCE_TOP_ADDRESS_N_IN && !INTR_ACK_OP_N_IN)
            ADDR_OUT <= TOP_ADDRESS;               // [RULE15]
         else
            ADDR_OUT <= BUS_DATA_IN;               // [RULE13]
      end
   end

   // float only with grant; a stray float request without grant is ignored
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         ADDR_OE_OUT <= 1'b1;
      else
         ADDR_OE_OUT <=
            ~(~FLOAT_ADDR_REG_N_IN & ~BUS_GRANT_N_IN); // [RULE14] [RULE17]
   end

   // oscillator level passed out to the connector pin
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         CRYSTAL_OSC_OUT <= 1'b0;
      else
         CRYSTAL_OSC_OUT <= OSC_IN;                // [RULE16]
   end
endmodule

// ### sim/cbg_card.sv
// backplane card model that places words on the shared data bus
`timescale 1ns/10ps
module cbg_card
(
   input  wire logic        clk_in,     // master clock
   input  wire logic        grant_n_in, // bus granted, low
   input  wire logic        cpu_oe_in,  // processor card drives bus
   input  wire logic [15:0] val_in,     // word to place
   output logic      [15:0] bus_out     // data bus level
);
   // drive only once granted; a released bus flips each cycle so a
   // stale word can never pass for a fresh one
   always_ff @(posedge clk_in)
      bus_out <= (!grant_n_in && !cpu_oe_in) ? val_in : ~bus_out;
endmodule

// ### sim/cbg_chk.sv
// port assertions for the processor card glue
`timescale 1ns/10ps
module cbg_chk
(
   input wire logic        CLK_SYS_IN,           // clock
   input wire logic        NRST_IN,              // clear
   input wire logic        CPU_SYNC_N_IN,        // sync in
   input wire logic [15:0] EXT_BRANCH_COND_N_IN, // conds
   input wire logic [3:0]  COND_SEL_IN,          // select
   input wire logic        FLOAT_ADDR_REG_N_IN,  // float
   input wire logic        BUS_GRANT_N_IN,       // grant
   input wire logic        PHASE1_OUT,           // phase one
   input wire logic        PHASE2_OUT,           // phase two
   input wire logic        SLOT_STROBE_1_N_OUT,  // slot one
   input wire logic        SLOT_STROBE_3_N_OUT,  // slot three
   input wire logic        SLOT_STROBE_4_N_OUT,  // slot four
   input wire logic        CPU_SYNC_N_OUT,       // sync out
   input wire logic        EXT_BRANCH_TAKE_OUT,  // taken
   input wire logic        ADDR_OE_OUT           // address drive
);
   logic take_exp; // expected branch flag
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!NRST_IN);
   // expectation spans the mux, so a wrong index or polarity shows
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
      if (!NRST_IN)
         take_exp <= 1'b0;
      else
         take_exp <= !EXT_BRANCH_COND_N_IN[COND_SEL_IN];
   no_overlap_a: assert property (!(PHASE1_OUT && PHASE2_OUT))
      else $error("both phases high");
   phase_alt_a: assert property (PHASE1_OUT |=> PHASE2_OUT)
      else $error("phase two missing");
   slot_order_a: assert property (!SLOT_STROBE_1_N_OUT |-> ##2
      !SLOT_STROBE_3_N_OUT ##1 !SLOT_STROBE_4_N_OUT ##1 !SLOT_STROBE_1_N_OUT)
      else $error("slot order broken");
   slot_one_a: assert property (!SLOT_STROBE_1_N_OUT |-> PHASE1_OUT)
      else $error("slot one without phase one");
   slot_four_a: assert property (!SLOT_STROBE_4_N_OUT |-> PHASE2_OUT)
      else $error("slot four without phase two");
   branch_sel_a: assert property (EXT_BRANCH_TAKE_OUT == take_exp)
      else $error("branch flag wrong");
   float_on_a: assert property (!FLOAT_ADDR_REG_N_IN &&
      !BUS_GRANT_N_IN |=> !ADDR_OE_OUT)
      else $error("address not floated");
   float_off_a: assert property (BUS_GRANT_N_IN |=> ADDR_OE_OUT)
      else $error("address floated without grant");
   sync_rise_a: assert property ($rose(CPU_SYNC_N_OUT) |->
      $fell(SLOT_STROBE_3_N_OUT))
      else $error("sync rose off slot three");
   sync_fall_a: assert property (!CPU_SYNC_N_IN |=> !CPU_SYNC_N_OUT)
      else $error("sync did not fall");
   cover property (!SLOT_STROBE_4_N_OUT);
   cover property ($rose(CPU_SYNC_N_OUT));
   cover property (!ADDR_OE_OUT);
endmodule
bind cbg_top cbg_chk cbg_chk_i
(
   .CLK_SYS_IN, .NRST_IN, .CPU_SYNC_N_IN, .EXT_BRANCH_COND_N_IN,
   .COND_SEL_IN, .FLOAT_ADDR_REG_N_IN, .BUS_GRANT_N_IN, .PHASE1_OUT,
   .PHASE2_OUT, .SLOT_STROBE_1_N_OUT, .SLOT_STROBE_3_N_OUT,
   .SLOT_STROBE_4_N_OUT, .CPU_SYNC_N_OUT, .EXT_BRANCH_TAKE_OUT, .ADDR_OE_OUT
);

// ### sim/cbg_top_tb.sv
// self-checking bench for the processor card glue
`timescale 1ns/10ps
module cbg_top_tb;
   import cbg_pkg::*;
   logic        clk, nrst, syn, dir, flt, gnt, osc, frc, p1, p2, s1, s3, s4;
   logic        sy_o, take, doe, aoe, osc_o;
   logic [15:0] cnd, cpud, val, bus, bo, co, ad;
   logic [3:0]  sel;
   logic [2:0]  ops;
   logic [4:0]  pat [4] = '{5'h13, 5'h0F, 5'h15, 5'h0E};
   logic [15:0] av  [3] = '{16'h1234, 16'h0F0F, 16'hC0DE};
   int          n_errors, total_checks;
   cbg_top cbg_top_i
   (
      .CLK_SYS_IN(clk), .NRST_IN(nrst), .CPU_SYNC_N_IN(syn),
      .EXT_BRANCH_COND_N_IN(cnd), .COND_SEL_IN(sel), .CPU_DRIVE_DIR_IN(dir),
      .CPU_DATA_IN(cpud), .BUS_DATA_IN(bus), .ADDR_READ_OP_N_IN(ops[0]),
      .BUS_ADDR_LOAD_N_IN(ops[1]), .INTR_ACK_OP_N_IN(ops[2]),
      .FLOAT_ADDR_REG_N_IN(flt), .BUS_GRANT_N_IN(gnt),
      .FORCE_TOP_ADDRESS_N_IN(frc), .OSC_IN(osc), .PHASE1_OUT(p1),
      .PHASE2_OUT(p2), .SLOT_STROBE_1_N_OUT(s1), .SLOT_STROBE_3_N_OUT(s3),
      .SLOT_STROBE_4_N_OUT(s4), .CPU_SYNC_N_OUT(sy_o),
      .EXT_BRANCH_TAKE_OUT(take), .BUS_DATA_OUT(bo), .BUS_DATA_OE_OUT(doe),
      .CPU_DATA_OUT(co), .ADDR_OUT(ad), .ADDR_OE_OUT(aoe),
      .CRYSTAL_OSC_OUT(osc_o)
   );
   cbg_card cbg_card_i
   (
      .clk_in(clk), .grant_n_in(gnt), .cpu_oe_in(doe), .val_in(val),
      .bus_out(bus)
   );
   // 40 MHz master clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // wait edges, then step past them so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // clear held, then the slot walk must start on the first edge
   task automatic t_ring;
      tick(4);
      chk(16'({p1, p2, s1, s3, s4}), 16'h0007);
      nrst = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         tick(1);
         chk(16'({p1, p2, s1, s3, s4}), 16'(pat[i % 4]));
      end
   endtask
   task automatic t_branch;
      for (int i = 0; i < 16; i++)
      begin
         sel = 4'(i);
         cnd = ~(16'h0001 << i);
         tick(1);
         chk(16'(take), 16'h0001);
         cnd = 16'h0001 << i;
         tick(1);
         chk(16'(take), 16'h0000);
      end
   endtask
   task automatic t_sync;
      syn = 1'b0;
      tick(2);
      chk(16'(sy_o), 16'h0000);
      syn = 1'b1;
      // the sync rise and the slot three strobe fall share one edge
      for (int i = 0; i < 8 && sy_o !== 1'b1; i++)
         tick(1);
      chk(16'(sy_o), 16'h0001);
      chk(16'(s3), 16'h0000);
   endtask
   task automatic t_data;
      dir = 1'b1;
      cpud = 16'hA5C3;
      osc = 1'b1;
      tick(8);
      chk(16'(doe), 16'h0001);
      chk(bo, 16'hA5C3);
      chk(16'(osc_o), 16'h0001);
      dir = 1'b0;
      val = 16'h3C5A;
      tick(8);
      chk(16'(doe), 16'h0000);
      chk(co, 16'h3C5A);
   endtask
   // each address operation captures; the register then holds
   task automatic t_addr;
      for (int j = 0; j < 3; j++)
      begin
         val = av[j];
         ops = ~(3'b001 << j);
         tick(8);
         ops = 3'b111;
         val = ~av[j];
         tick(8);
         chk(ad, av[j]);
      end
      ops = 3'b011;
      frc = 1'b0;
      tick(8);
      chk(ad, TOP_ADDRESS);
      ops = 3'b111;
      frc = 1'b1;
   endtask
   task automatic t_float;
      gnt = 1'b1;
      flt = 1'b0;
      tick(2);
      chk(16'(aoe), 16'h0001);
      gnt = 1'b0;
      tick(2);
      chk(16'(aoe), 16'h0000);
      flt = 1'b1;
      tick(2);
      chk(16'(aoe), 16'h0001);
   endtask
   initial
   begin
      nrst = 1'b0;
      syn = 1'b1;
      dir = 1'b0;
      flt = 1'b1;
      gnt = 1'b0;
      osc = 1'b0;
      frc = 1'b1;
      cnd = 16'hFFFF;
      sel = 4'h0;
      cpud = 16'h0000;
      val = 16'h0000;
      ops = 3'b111;
      t_ring();
      t_branch();
      t_sync();
      t_data();
      t_addr();
      t_float();
      give_verdict();
   end
   // the run needs some 125 cycles; this cuts a hang at 2000
   initial
   begin
      #50000;
      n_errors++;
      give_verdict();
   end
endmodule
